/* hw/mmp_cfg.svh */
// Offsets, field positions, reset values and fixed pages of the paging register bank
`ifndef MMP_CFG_SVH
`define MMP_CFG_SVH
`define MMP_OFS_RSVD_A   16'h000A
`define MMP_OFS_MODE     16'h000B
`define MMP_OFS_RSVD_B   16'h0010
`define MMP_OFS_DIRECT   16'h0011
`define MMP_OFS_RSVD_C   16'h0012
`define MMP_OFS_RSVD_D   16'h0013
`define MMP_OFS_RSVD_E   16'h0014
`define MMP_OFS_PAGE     16'h0015
`define MMP_MODE_BIT     7
`define MMP_DIRECT_RST   8'h00
`define MMP_PAGE_RST     4'hE
`define MMP_PAGE_LO      4'hC
`define MMP_PAGE_MID     4'hD
`define MMP_PAGE_HI      4'hF
`endif

/* hw/mmp_pkg.sv */
// Types of the paging register bank
package mmp_pkg;
  typedef enum logic [1:0] {
    MMP_ST_RESET = 2'b00,
    MMP_ST_RUN   = 2'b01
  } mmp_phase_t;

  typedef struct packed {
    logic       sel;
    logic       wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mmp_bus_t;

  typedef struct packed {
    mmp_phase_t phase;
    logic       mode_select_bit;
    logic       mode_lock;
    logic [7:0] direct_page_index_bits;
    logic       direct_written;
    logic [3:0] page_index_bits;
    logic [7:0] rdata;
  } mmp_state_t;
endpackage

/* hw/mmp_regs.sv */
// Mode, direct-page and program-page register bank with address expansion
`timescale 1ns/1ps
`include "mmp_cfg.svh"

// Notes on behaviour
// - Mode follows pin during reset; pin level latched into mode bit on the first clock edge after release.
// - Out of reset the mode bit, not the pin, sets the operating mode.
// - Disallowed mode write keeps bit and locks further writes, unless in special mode.
// - All mode register writes are ignored while secured.
// - Mode register always readable; writes change the bit only for allowed transitions.
// - Direct register writable anytime in special mode, only first write in normal.
// - Direct index forms address bits 15 to 8 above the low byte.
// - Direct page is 256 bytes, same in global and local mapping.
// - Page bits pick the 16 kB flash block seen at 0x8000 to 0xBFFF.
// - Page register always read/write; upper four bits read zero.
// - CPU call/return path updates the page register within the instruction.
// - Local 0x0000 to 0x3FFF maps to flash page 0x0C.
// - Local 0x4000 to 0x7FFF maps to flash page 0x0D.
// - Local 0xC000 to 0xFFFF maps to flash page 0x0F.
// - Page register resets to 0x0E giving linear flash after reset.
// - Normal single-chip mode runs application code without an external bus.
// - Special mode lets background debug control the CPU, waiting on the serial pin.
// - Special mode enters background debug state after every reset.
module mmp_regs
  import mmp_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        mode_pin,
  input  wire logic        secured,
  input  wire mmp_bus_t    bus,
  input  wire logic        call_page_wr,
  input  wire logic [3:0]  call_page_val,
  input  wire logic [7:0]  direct_low_byte,
  input  wire logic [15:0] local_addr,
  output logic [7:0]       rdata,
  output logic             normal_single_chip,
  output logic             external_bus_en,
  output logic             background_debug_state,
  output logic [15:0]      direct_addr,
  output logic [17:0]      global_addr
);

  mmp_state_t st_r;
  mmp_state_t st_nxt;
  logic       mode_eff;
  logic       wr_mode;
  logic       wr_dir;
  logic       wr_page;
  logic       new_mode;
  logic       allowed;
  logic [3:0] page_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Mode: pin while in reset phase, stored bit afterwards (1 = special)
  assign mode_eff = (st_r.phase == MMP_ST_RESET) ? mode_pin : st_r.mode_select_bit;
  assign wr_mode  = bus.sel && bus.wr && bus.addr == `MMP_OFS_MODE;
  assign wr_dir   = bus.sel && bus.wr && bus.addr == `MMP_OFS_DIRECT;
  assign wr_page  = bus.sel && bus.wr && bus.addr == `MMP_OFS_PAGE;
  assign new_mode = bus.wdata[`MMP_MODE_BIT];
  // Only special to normal is a legal change; rewriting same value is harmless
  assign allowed  = (new_mode == st_r.mode_select_bit) || (st_r.mode_select_bit && !new_mode);

  always_comb begin
    st_nxt = st_r;
    if (st_r.phase == MMP_ST_RESET) begin
      // First edge after release catches the strap
      st_nxt.phase           = MMP_ST_RUN;
      st_nxt.mode_select_bit = mode_pin;
    end else begin
      if (wr_mode && !secured && !st_r.mode_lock) begin
        if (allowed) begin
          st_nxt.mode_select_bit = new_mode;
        end else if (!st_r.mode_select_bit) begin
          st_nxt.mode_lock = 1'b1;
        end
      end
      if (wr_dir && (st_r.mode_select_bit || !st_r.direct_written)) begin
        st_nxt.direct_page_index_bits = bus.wdata;
        st_nxt.direct_written         = 1'b1;
      end
      // CPU call/return path wins over a bus write in the same cycle
      if (call_page_wr) begin
        st_nxt.page_index_bits = call_page_val;
      end else if (wr_page) begin
        st_nxt.page_index_bits = bus.wdata[3:0];
      end
    end
    st_nxt.rdata = 8'h00;
    if (bus.sel && !bus.wr) begin
      unique case (bus.addr)
        `MMP_OFS_MODE:   st_nxt.rdata = {mode_eff, 7'h00};
        `MMP_OFS_DIRECT: st_nxt.rdata = st_r.direct_page_index_bits;
        `MMP_OFS_PAGE:   st_nxt.rdata = {4'h0, st_r.page_index_bits};
        default:         st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r.phase                  <= MMP_ST_RESET;
      st_r.mode_select_bit        <= 1'b0;
      st_r.mode_lock              <= 1'b0;
      st_r.direct_page_index_bits <= `MMP_DIRECT_RST;
      st_r.direct_written         <= 1'b0;
      st_r.page_index_bits        <= `MMP_PAGE_RST;
      st_r.rdata                  <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode outputs and address expansion
  assign rdata                  = st_r.rdata;
  assign normal_single_chip     = !mode_eff;
  assign external_bus_en        = 1'b0;
  // Debug logic holds the CPU until released externally; flag only marks mode
  assign background_debug_state = mode_eff;
  assign direct_addr            = {st_r.direct_page_index_bits, direct_low_byte};

  always_comb begin
    unique case (local_addr[15:14])
      2'b00: page_sel = `MMP_PAGE_LO;
      2'b01: page_sel = `MMP_PAGE_MID;
      2'b10: page_sel = st_r.page_index_bits;
      2'b11: page_sel = `MMP_PAGE_HI;
    endcase
  end
  assign global_addr = {page_sel, local_addr[13:0]};

  ////////////////////////////////////////////////////////////////////////////
  property p_latch;
    @(posedge mclk) disable iff (rst)
      st_r.phase == MMP_ST_RESET |=> st_r.mode_select_bit == $past(mode_pin);
  endproperty
  a_latch: assert property (p_latch) else $error("mode pin not latched");

  property p_secure;
    @(posedge mclk) disable iff (rst)
      st_r.phase == MMP_ST_RUN && secured && !call_page_wr |=> $stable(st_r.mode_select_bit);
  endproperty
  a_secure: assert property (p_secure) else $error("mode changed while secured");

  property p_lock;
    @(posedge mclk) disable iff (rst)
      st_r.mode_lock |=> $stable(st_r.mode_select_bit);
  endproperty
  a_lock: assert property (p_lock) else $error("locked mode bit changed");

  property p_nomode_up;
    @(posedge mclk) disable iff (rst)
      st_r.phase == MMP_ST_RUN && !st_r.mode_select_bit |=> !st_r.mode_select_bit;
  endproperty
  a_nomode_up: assert property (p_nomode_up) else $error("illegal normal to special");

  property p_dir_once;
    @(posedge mclk) disable iff (rst)
      st_r.direct_written && !st_r.mode_select_bit |=> $stable(st_r.direct_page_index_bits);
  endproperty
  a_dir_once: assert property (p_dir_once) else $error("direct rewritten in normal");

  property p_call;
    @(posedge mclk) disable iff (rst)
      st_r.phase == MMP_ST_RUN && call_page_wr |=> st_r.page_index_bits == $past(call_page_val);
  endproperty
  a_call: assert property (p_call) else $error("call page update lost");

  property p_page_rd;
    @(posedge mclk) disable iff (rst)
      bus.sel && !bus.wr && bus.addr == `MMP_OFS_PAGE |=> rdata[7:4] == 4'h0;
  endproperty
  a_page_rd: assert property (p_page_rd) else $error("page upper bits not zero");

  property p_window;
    @(posedge mclk) disable iff (rst)
      local_addr[15:14] == 2'b10 |-> global_addr[17:14] == st_r.page_index_bits;
  endproperty
  a_window: assert property (p_window) else $error("window page wrong");

  property p_fixed;
    @(posedge mclk) disable iff (rst)
      local_addr[15:14] == 2'b11 |-> global_addr[17:14] == `MMP_PAGE_HI;
  endproperty
  a_fixed: assert property (p_fixed) else $error("top page not fixed");

endmodule

/* test/mmp_master.sv */
// Bus master model standing in for the CPU and debug masters
`timescale 1ns/1ps
module mmp_master
  import mmp_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic [7:0] rdata,
  output mmp_bus_t        bus,
  output logic [7:0]      rd
);
  initial bus = '0;
  initial rd = 8'h00;
  // Entered at a falling edge; one access then one idle cycle
  task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
    bus <= '{1'b1, wr, a, d};
    @(negedge mclk);
    rd = rdata;
    // Released lines show the inverse, never a stale copy
    bus <= '{1'b0, ~wr, ~a, ~d};
    @(negedge mclk);
  endtask
endmodule

/* test/tb.sv */
// Self-checking bench for the paging register bank
`timescale 1ns/1ps
`include "mmp_cfg.svh"
module tb;
  import mmp_pkg::*;
  logic        mclk, rst, mode_pin, secured, call_page_wr, nsc, ext_en, dbg;
  logic [3:0]  call_page_val;
  logic [7:0]  direct_low_byte, rdata, v;
  logic [15:0] local_addr, direct_addr;
  logic [17:0] global_addr;
  logic [15:0] rsv [5] = '{`MMP_OFS_RSVD_A, `MMP_OFS_RSVD_B, `MMP_OFS_RSVD_C,
                           `MMP_OFS_RSVD_D, `MMP_OFS_RSVD_E};
  mmp_bus_t    bus;
  int          bad_count, n_tests;
  int          seed = 32'hd8555129;
  mmp_regs u_mmp_regs (.mclk(mclk), .rst(rst), .mode_pin(mode_pin), .secured(secured),
    .bus(bus), .call_page_wr(call_page_wr), .call_page_val(call_page_val),
    .direct_low_byte(direct_low_byte), .local_addr(local_addr), .rdata(rdata),
    .normal_single_chip(nsc), .external_bus_en(ext_en), .background_debug_state(dbg),
    .direct_addr(direct_addr), .global_addr(global_addr));
  mmp_master u_mmp_master (.mclk(mclk), .rdata(rdata), .bus(bus), .rd());
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task automatic chka(input logic [17:0] g, input logic [17:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  function automatic logic [17:0] exp_ga(input logic [3:0] pg, input logic [15:0] a);
    case (a[15:14])
      2'b00: pg = `MMP_PAGE_LO;
      2'b01: pg = `MMP_PAGE_MID;
      2'b11: pg = `MMP_PAGE_HI;
      default: pg = pg;
    endcase
    return {pg, a[13:0]};
  endfunction
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    u_mmp_master.acc(1'b0, a, 8'h00);
    chk8(u_mmp_master.rd, e, "read data");
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    u_mmp_master.acc(1'b1, a, d);
  endtask
  task automatic do_reset(input logic pin);
    rst <= 1'b1;
    mode_pin <= ~pin;
    repeat (3) @(negedge mclk);
    chk8({7'h00, nsc}, {7'h00, pin}, "pin in reset");
    mode_pin <= pin;
    repeat (3) @(negedge mclk);
    rst <= 1'b0;
    // First edge after release only latches the pin
    @(negedge mclk);
  endtask
  task automatic summarize;
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    bad_count++;
    summarize;
  end
  initial begin
    {rst, mode_pin, secured, call_page_wr, call_page_val} = 8'h80;
    {direct_low_byte, local_addr} = '0;
    do_reset(1'b1);
    chk8({nsc, ext_en, dbg}, 8'h01, "mode outputs");
    rd(`MMP_OFS_MODE, 8'h80);
    rd(`MMP_OFS_PAGE, 8'h0E);
    rd(`MMP_OFS_DIRECT, 8'h00);
    foreach (rsv[i]) begin
      wr(rsv[i], 8'hFF);
      rd(rsv[i], 8'h00);
    end
    mode_pin <= 1'b0;
    rd(`MMP_OFS_MODE, 8'h80);
    for (int i = 0; i < 12; i++) begin
      v = 8'($random(seed));
      wr(`MMP_OFS_PAGE, v);
      rd(`MMP_OFS_PAGE, {4'h0, v[3:0]});
      wr(`MMP_OFS_DIRECT, ~v);
      direct_low_byte <= 8'($random(seed));
      local_addr <= {i[1:0], 14'($random(seed))};
      #1;
      chka(18'(direct_addr), {2'b00, ~v, direct_low_byte}, "direct");
      chka(global_addr, exp_ga(v[3:0], local_addr), "global");
    end
    $display("test paging done");
    call_page_val <= 4'h5;
    call_page_wr <= 1'b1;
    fork
      wr(`MMP_OFS_PAGE, 8'h09);
      begin
        @(negedge mclk);
        call_page_wr <= 1'b0;
      end
    join
    rd(`MMP_OFS_PAGE, 8'h05);
    secured <= 1'b1;
    wr(`MMP_OFS_MODE, 8'h00);
    rd(`MMP_OFS_MODE, 8'h80);
    secured <= 1'b0;
    wr(`MMP_OFS_MODE, 8'h00);
    rd(`MMP_OFS_MODE, 8'h00);
    wr(`MMP_OFS_MODE, 8'h80);
    rd(`MMP_OFS_MODE, 8'h00);
    chk8({nsc, ext_en, dbg}, 8'h04, "normal outputs");
    $display("test mode done");
    do_reset(1'b0);
    rd(`MMP_OFS_MODE, 8'h00);
    wr(`MMP_OFS_DIRECT, 8'h3C);
    wr(`MMP_OFS_DIRECT, 8'hC3);
    rd(`MMP_OFS_DIRECT, 8'h3C);
    $display("test normal done");
    summarize;
  end
endmodule
